// ===== core/mmss_top.sv
// reduced-mode status serializer: strap capture, group select, frame shifter
//
// Behaviour
// (R1) Strap high while reset is held selects reduced mode, else normal.
// (R2) In reduced mode the command pin in reset enables polarity fix at 1.
// (R3) The outside party drops the strap within 100 ns of reset release.
// (R4) The mode is caught only during reset and holds until the next one.
// (R5) Reduced mode refuses the normal management get and set commands.
// (R6) Select 00 SQE+polarity, 01 bit rate, 10 loopback+link, 11 partition.
// (R7) A frame is ten slots: attachment bit, ports 0 to 7, one blank slot.
// (R8) The window strobe is active in the blank slot after the status bits.
// (R9) Each status bit stands for exactly one 100 ns slot on the output.
// (R10) Select pins are read once per frame, on the edge before strobe falls.
// (R11) Select pins may move at any time; a change acts at the next sample.
// (R12) Output and strobe keep the carrier activity stream format and timing.
// (R13) A link bit reads 0 in link fail and 1 once the link works.
// (R14) A polarity bit reads 0 for normal and 1 for reversed polarity.
// (R15) One frame carries a single group across its nine status slots.
`default_nettype none
module mmss_top (
  // clock (crystal clock) and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // strap and select pins
  input wire logic MODE_STRAP_IN,
  input wire logic SERIAL_CMD_IN,
  input wire logic SERIAL_CLK_IN,
  // per-port status from the repeater core
  input wire mmss_pkg::mmss_status_t STATUS_IN,
  // serial stream
  output logic SERIAL_STATUS_OUT,
  output logic WINDOW_STROBE_OUT,
  // mode indications
  output logic MIN_MODE_OUT,
  output logic POL_CORRECT_EN_OUT,
  output logic MGMT_CMD_ENABLE_OUT
);
  import mmss_pkg::*;

  logic min_mode_ff;
  logic nxt_min_mode;
  logic pol_en_ff;
  logic nxt_pol_en;

  mmss_state_t state_ff;
  mmss_state_t nxt_state;
  logic [CYC_W-1:0] cyc_ff;
  logic [CYC_W-1:0] nxt_cyc;
  logic [BIT_W-1:0] bit_ff;
  logic [BIT_W-1:0] nxt_bit;
  logic [1:0] group_ff;
  logic [1:0] nxt_group;
  logic serial_ff;
  logic nxt_serial;
  logic strobe_ff;
  logic nxt_strobe;

  logic [STATUS_BITS-1:0] frame_vec;
  logic [STATUS_BITS-1:0] grp_vec [4];
  logic sample_pt;
  logic slot_start;
  logic first_bit;

  localparam logic [6:0] POS_LAST = 7'(FRAME_SLOTS * SLOT_CYC - 1);
  localparam logic [6:0] POS_BLANK = 7'(STATUS_BITS * SLOT_CYC);
  logic [6:0] chk_pos_ff;
  logic [6:0] nxt_chk_pos;

  // strap latch: follows the pins while reset is held, frozen after
  // release; needs the clock running during reset
  always_comb begin
    nxt_min_mode = min_mode_ff;
    nxt_pol_en = pol_en_ff;
    if (RESET_IN) begin
      nxt_min_mode = MODE_STRAP_IN; // R1 R4
      nxt_pol_en = MODE_STRAP_IN & SERIAL_CMD_IN; // R2
    end
  end

  always_ff @(posedge CLK_IN) begin
    min_mode_ff <= nxt_min_mode;
    pol_en_ff <= nxt_pol_en;
  end

  assign MIN_MODE_OUT = min_mode_ff;
  assign POL_CORRECT_EN_OUT = pol_en_ff;
  assign MGMT_CMD_ENABLE_OUT = ~min_mode_ff; // R5

  // group vectors, bit 0 is the attachment port
  assign grp_vec[GRP_SQE_POL] =
    {STATUS_IN.tp_pol_reversed, STATUS_IN.aui_sqe_err}; // R6 R14
  assign grp_vec[GRP_BIT_RATE] = STATUS_IN.bit_rate_err; // R6
  assign grp_vec[GRP_LOOP_LINK] =
    {STATUS_IN.tp_link_pass, STATUS_IN.aui_loopback}; // R6 R13
  assign grp_vec[GRP_PARTITION] = STATUS_IN.partitioned; // R6
  // next group, so the first slot already shows the new selection
  assign frame_vec = grp_vec[nxt_group]; // R15

  // last cycle of the blank slot, the edge before the strobe falls
  assign sample_pt = (state_ff == ST_BLANK) && (cyc_ff == CYC_LAST);

  always_comb begin
    nxt_state = state_ff;
    nxt_cyc = cyc_ff;
    nxt_bit = bit_ff;
    nxt_group = group_ff;
    unique case (state_ff)
      ST_OFF: begin
        nxt_cyc = CYC_RST;
        nxt_bit = BIT_RST;
        if (min_mode_ff) begin
          nxt_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (cyc_ff == CYC_LAST) begin // R9
          nxt_cyc = CYC_RST;
          nxt_bit = bit_ff + 4'h1; // R7
          if (bit_ff == BIT_LAST_STATUS) begin
            nxt_state = ST_BLANK; // R8
          end
        end else begin
          nxt_cyc = cyc_ff + 4'h1;
        end
      end
      ST_BLANK: begin
        if (cyc_ff == CYC_LAST) begin
          nxt_cyc = CYC_RST;
          nxt_bit = BIT_RST;
          nxt_state = ST_SHIFT;
          nxt_group = {SERIAL_CLK_IN, SERIAL_CMD_IN}; // R10 R11
        end else begin
          nxt_cyc = cyc_ff + 4'h1;
        end
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
  end

  // outputs registered from the next counters so they line up with them
  always_comb begin
    nxt_serial = 1'b0;
    nxt_strobe = 1'b0;
    if (nxt_state == ST_SHIFT) begin
      nxt_serial = frame_vec[nxt_bit]; // R7 R9 R12
    end
    if (nxt_state == ST_BLANK) begin
      nxt_strobe = 1'b1; // R8 R12
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_ff <= ST_OFF;
      cyc_ff <= CYC_RST;
      bit_ff <= BIT_RST;
      group_ff <= GRP_RST;
      serial_ff <= 1'b0;
      strobe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cyc_ff <= nxt_cyc;
      bit_ff <= nxt_bit;
      group_ff <= nxt_group;
      serial_ff <= nxt_serial;
      strobe_ff <= nxt_strobe;
    end
  end

  assign SERIAL_STATUS_OUT = serial_ff;
  assign WINDOW_STROBE_OUT = strobe_ff;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  assign slot_start = (state_ff == ST_SHIFT) && (cyc_ff == CYC_RST);
  assign first_bit = frame_vec[0];

  // shadow frame position for the checks, apart from the shifter counters
  always_comb begin
    nxt_chk_pos = chk_pos_ff;
    if ((state_ff == ST_OFF) || (chk_pos_ff == POS_LAST)) begin
      nxt_chk_pos = 7'h00;
    end else begin
      nxt_chk_pos = chk_pos_ff + 7'h01;
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      chk_pos_ff <= 7'h00;
    end else begin
      chk_pos_ff <= nxt_chk_pos;
    end
  end

  a_strobe_width: assert property ( // R8
    $rose(strobe_ff) |=> strobe_ff [*8] ##1 strobe_ff ##1 !strobe_ff)
    else $error("strobe not ten cycles wide");

  a_frame_period: assert property ( // R7
    $rose(strobe_ff) |-> ##100 $rose(strobe_ff))
    else $error("frame is not one hundred cycles");

  a_mode_frozen: assert property ( // R4
    !RESET_IN |=> $stable(min_mode_ff) && $stable(pol_en_ff))
    else $error("mode changed outside reset");

  a_normal_quiet: assert property ( // R1
    !min_mode_ff |-> !serial_ff && !strobe_ff)
    else $error("stream active in normal mode");

  a_mgmt_block: assert property ( // R5
    MGMT_CMD_ENABLE_OUT != min_mode_ff)
    else $error("management gate wrong for mode");

  a_group_hold: assert property ( // R15
    !sample_pt |=> $stable(group_ff))
    else $error("group changed inside a frame");

  a_group_sample: assert property ( // R10
    sample_pt |=> (group_ff == {$past(SERIAL_CLK_IN), $past(SERIAL_CMD_IN)})
      && $fell(strobe_ff))
    else $error("select not taken at strobe fall");

  a_bit_hold: assert property ( // R9
    (state_ff == ST_SHIFT) && (cyc_ff != CYC_RST) |-> $stable(serial_ff))
    else $error("status bit changed inside a slot");

  a_blank_low: assert property ( // R8
    strobe_ff |-> !serial_ff)
    else $error("data during blank slot");

  a_first_bit: assert property ( // R7
    $fell(strobe_ff) |-> serial_ff == $past(first_bit))
    else $error("attachment bit not first");

  a_cyc_range: assert property ( // R9
    cyc_ff <= CYC_LAST)
    else $error("slot counter out of range");

  a_bit_range: assert property ( // R7
    bit_ff <= BIT_BLANK)
    else $error("slot index out of range");

  a_state_onehot: assert property ( // R7
    $onehot(state_ff))
    else $error("shifter state not one-hot");

  a_pol_mode: assert property ( // R2
    pol_en_ff |-> min_mode_ff)
    else $error("polarity fix on in normal mode");

  a_bit_step: assert property ( // R7
    (state_ff == ST_SHIFT) && (cyc_ff == CYC_LAST)
      && (bit_ff != BIT_LAST_STATUS) |=> bit_ff == $past(bit_ff) + 4'h1)
    else $error("slot index did not step by one");

  a_blank_enter: assert property ( // R8
    (state_ff == ST_SHIFT) && (cyc_ff == CYC_LAST)
      && (bit_ff == BIT_LAST_STATUS) |=> strobe_ff && !serial_ff)
    else $error("blank slot missing after port 7");

  a_strobe_pos: assert property ( // R8 R12
    (state_ff != ST_OFF) |-> strobe_ff == (chk_pos_ff >= POS_BLANK))
    else $error("strobe out of place in frame");

  a_frame_start: assert property ( // R7 R12
    (state_ff != ST_OFF) && (chk_pos_ff == 7'h00)
      |-> (bit_ff == BIT_RST) && (cyc_ff == CYC_RST))
    else $error("frame does not start at slot zero");

  a_map_sqe: assert property ( // R6 R15
    slot_start && (bit_ff == BIT_RST) && (group_ff == GRP_SQE_POL)
      |-> serial_ff == $past(STATUS_IN.aui_sqe_err))
    else $error("sqe bit not first in its group");

  a_map_pol: assert property ( // R6 R14
    slot_start && (bit_ff == 4'h1) && (group_ff == GRP_SQE_POL)
      |-> serial_ff == $past(STATUS_IN.tp_pol_reversed[0]))
    else $error("port 0 polarity bit misplaced");

  a_map_link: assert property ( // R6 R13
    slot_start && (bit_ff == 4'h1) && (group_ff == GRP_LOOP_LINK)
      |-> serial_ff == $past(STATUS_IN.tp_link_pass[0]))
    else $error("port 0 link bit misplaced");

  a_map_rate: assert property ( // R6 R15
    slot_start && (bit_ff == BIT_RST) && (group_ff == GRP_BIT_RATE)
      |-> serial_ff == $past(STATUS_IN.bit_rate_err[0]))
    else $error("bit rate bit not first in its group");

  a_map_part: assert property ( // R6 R7
    slot_start && (bit_ff == BIT_LAST_STATUS) && (group_ff == GRP_PARTITION)
      |-> serial_ff == $past(STATUS_IN.partitioned[8]))
    else $error("port 7 partition bit misplaced");

  c_min_frame: cover property ($rose(strobe_ff));
  c_grp_part: cover property (sample_pt ##1 group_ff == GRP_PARTITION);
  c_grp_link: cover property (sample_pt ##1 group_ff == GRP_LOOP_LINK);
  c_grp_rate: cover property (sample_pt ##1 group_ff == GRP_BIT_RATE);
  c_grp_sqe: cover property (sample_pt ##1 group_ff == GRP_SQE_POL);
endmodule : mmss_top
`default_nettype wire

// ===== include/mmss_pkg.sv
// shared constants and carrier types of the reduced-mode status serializer
`default_nettype none
package mmss_pkg;
  localparam int CLK_MHZ = 100;
  localparam int SLOT_NS = 100;
  localparam int SLOT_CYC_INT = (SLOT_NS * CLK_MHZ + 999) / 1000;
  localparam int SLOT_CYC = (SLOT_CYC_INT < 1) ? 1 : SLOT_CYC_INT;
  localparam int CYC_W = 4;
  localparam int TP_PORTS = 8;
  localparam int STATUS_BITS = 9;
  localparam int FRAME_SLOTS = 10;
  localparam int BIT_W = 4;
  localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(SLOT_CYC - 1);
  localparam logic [BIT_W-1:0] BIT_BLANK = BIT_W'(FRAME_SLOTS - 1);
  localparam logic [BIT_W-1:0] BIT_LAST_STATUS = BIT_W'(STATUS_BITS - 1);
  localparam logic [BIT_W-1:0] BIT_RST = 4'h0;
  localparam logic [CYC_W-1:0] CYC_RST = 4'h0;
  localparam logic [1:0] GRP_SQE_POL = 2'h0;
  localparam logic [1:0] GRP_BIT_RATE = 2'h1;
  localparam logic [1:0] GRP_LOOP_LINK = 2'h2;
  localparam logic [1:0] GRP_PARTITION = 2'h3;
  localparam logic [1:0] GRP_RST = GRP_SQE_POL;

  typedef struct packed {
    logic aui_loopback;
    logic aui_sqe_err;
    logic [TP_PORTS-1:0] tp_link_pass;
    logic [TP_PORTS-1:0] tp_pol_reversed;
    logic [STATUS_BITS-1:0] partitioned;
    logic [STATUS_BITS-1:0] bit_rate_err;
  } mmss_status_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_SHIFT = 3'b010,
    ST_BLANK = 3'b100
  } mmss_state_t;
endpackage : mmss_pkg
`default_nettype wire

// ===== tb/mmss_led_latch.sv
// behavioural serial-to-parallel converter and led latch
`default_nettype none
module mmss_led_latch (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic serial_in,
  input wire logic strobe_in,
  output logic [8:0] leds_out,
  output logic [7:0] gap_out,
  output logic latch_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] shift_ff;
  logic strobe_ff;
  // samples mid-slot, away from the edges where the stream moves
  always @(negedge clk_in or posedge rst_in) begin
    latch_out <= 1'b0;
    if (rst_in) begin
      gap_out <= 8'h00;
      strobe_ff <= 1'b0;
    end else begin
      strobe_ff <= strobe_in;
      if (!strobe_in) gap_out <= gap_out + 8'h01;
      if (!strobe_in && (gap_out % 10 == 4))
        shift_ff <= {serial_in, shift_ff[8:1]};
      if (strobe_in && !strobe_ff) begin
        leds_out <= shift_ff;
        latch_out <= 1'b1;
      end
      if (strobe_in && strobe_ff) gap_out <= 8'h00;
    end
  end
endmodule : mmss_led_latch
`default_nettype wire

// ===== tb/mmss_top_tb.sv
// self-checking bench of the reduced-mode status serializer
`default_nettype none
module mmss_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mmss_pkg::*;
  // the first frame after reset also counts the idle cycle before it
  localparam logic [7:0] GAP_RUN = 8'(STATUS_BITS * SLOT_CYC);
  localparam logic [7:0] GAP_FIRST = GAP_RUN + 8'h01;
  logic clk = 1'b0, rst = 1'b1, strap = 1'b0, cmd = 1'b0, sclk = 1'b0;
  mmss_status_t st = '0;
  mmss_status_t ns;
  logic so, sto, mm, pe, me, lat, watch = 1'b0, busy_seen = 1'b0;
  logic [8:0] leds;
  logic [16:0] e;
  logic [7:0] gap;
  logic [15:0] rnd = 16'h0345;
  logic [1:0] gn;
  logic [16:0] expq[$];
  int n_errors = 0, tests_run = 0, cyc = 0;
  mmss_top dut_u (.CLK_IN(clk), .RESET_IN(rst), .MODE_STRAP_IN(strap),
    .SERIAL_CMD_IN(cmd), .SERIAL_CLK_IN(sclk), .STATUS_IN(st),
    .SERIAL_STATUS_OUT(so), .WINDOW_STROBE_OUT(sto), .MIN_MODE_OUT(mm),
    .POL_CORRECT_EN_OUT(pe), .MGMT_CMD_ENABLE_OUT(me));
  mmss_led_latch far_u (.clk_in(clk), .rst_in(rst), .serial_in(so),
    .strobe_in(sto), .leds_out(leds), .gap_out(gap), .latch_out(lat));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  function automatic logic [8:0] grp(input logic [1:0] g,
                                     input mmss_status_t s);
    case (g)
      2'h0: return {s.tp_pol_reversed, s.aui_sqe_err};
      2'h1: return s.bit_rate_err;
      2'h2: return {s.tp_link_pass, s.aui_loopback};
      default: return s.partitioned;
    endcase
  endfunction : grp
  function automatic mmss_status_t rand_st();
    logic [47:0] v;
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      v = {v[31:0], rnd};
    end
    return mmss_status_t'(v[35:0]);
  endfunction : rand_st
  task automatic check(input string name, input logic [8:0] exp,
                       input logic [8:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      stop_test();
    end
  end
  // takes the oldest expected frame whenever the far side latches one
  always @(posedge clk) begin
    if (watch) busy_seen <= busy_seen | so | sto;
    if (lat === 1'b1) begin
      e = expq.pop_front();
      check("frame", e[8:0], leds);
      check("gap", {1'b0, e[16:9]}, {1'b0, gap});
    end
  end
  initial begin
    // normal mode: strap low, command level ignored
    cmd <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    watch <= 1'b1;
    repeat (150) @(posedge clk);
    check("mode", 9'h001, {6'h00, mm, pe, me});
    check("idle", 9'h000, {8'h00, busy_seen});
    watch <= 1'b0;
    rst <= 1'b1;
    strap <= 1'b1;
    ns = rand_st();
    st <= ns;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    strap <= 1'b0;
    expq.push_back({GAP_FIRST, grp(2'h0, ns)});
    repeat (2) @(posedge clk);
    check("mode", 9'h006, {6'h00, mm, pe, me});
    for (int i = 0; i < 12; i++) begin
      // select moves twice mid-frame; only the last level counts
      repeat (30) @(posedge clk);
      {sclk, cmd} <= rnd[1:0];
      repeat (30) @(posedge clk);
      gn = 2'(i + 1);
      {sclk, cmd} <= gn;
      do @(posedge clk); while (sto !== 1'b1);
      ns = rand_st();
      st <= ns;
      expq.push_back({GAP_RUN, grp(gn, ns)});
    end
    repeat (105) @(posedge clk);
    check("left", 9'h000, 9'(expq.size()));
    check("mode", 9'h006, {6'h00, mm, pe, me});
    // reduced mode with polarity correction left off
    rst <= 1'b1;
    strap <= 1'b1;
    cmd <= 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    strap <= 1'b0;
    repeat (2) @(posedge clk);
    check("mode", 9'h004, {6'h00, mm, pe, me});
    stop_test();
  end
endmodule : mmss_top_tb
`default_nettype wire
